// file: src/gsc_regs.vh
`ifndef GSC_REGS_VH
`define GSC_REGS_VH
// ****************************************************************
// register map (APB byte offsets)
// ****************************************************************
`define GSC_CTRL_OFS 12'h000
`define GSC_STAT_OFS 12'h004
`define GSC_ERR_OFS 12'h008
// ****************************************************************
// control fields
// ****************************************************************
`define GSC_CTRL_MODE_LSB 0
`define GSC_CTRL_MODE_MSB 2
`define GSC_CTRL_EXT_BIT 3
`define GSC_CTRL_RESET 32'h00000005
// ****************************************************************
// mode codes
// ****************************************************************
`define GSC_MODE_1 3'h1
`define GSC_MODE_5 3'h5
`define GSC_MODE_6 3'h6
// ****************************************************************
// error fields
// ****************************************************************
`define GSC_ERR_TIMEOUT_BIT 0
`define GSC_ERR_FAULTY_BIT 1
`define GSC_ERR_SYNC_BIT 2
// ****************************************************************
// clock in Hz, timing in ms
// ****************************************************************
`define GSC_CLK_HZ 125000000
`define GSC_END_MS 100
`define GSC_SYNC_MS 60000
`define GSC_TMO_MS 600000
`define GSC_TMO_EXT_MS 360000000
`define GSC_PAIR_MS 500
`define GSC_NOFIELD_MS 4000
`define GSC_PMODE_MS 3600000
`define GSC_PRESS_MIN_MS 150
`define GSC_PRESS_MAX_MS 4000
`define GSC_FILT_LONG_MS 2000
`define GSC_FILT_SHORT_MS 1000
`define GSC_BLINK_MS 500
`endif

// file: src/gsc_sync.v
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// three-stage input synchroniser with agreement check
// ****************************************************************
module gsc_sync #(
    parameter W = 5
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // data
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // change counts once stages two and three agree
            if (s2_q == s3_q)
                dout <= s3_q;
        end
    end
endmodule // gsc_sync
`default_nettype wire

// file: src/gsc_top.v
`timescale 1ns/100ps
`default_nettype none
`include "gsc_regs.vh"
// How it works
// - gate switch removed ends gating within 100ms
// - bridging time limited, timeout error, outputs off
// - sync beams lost over 60s, outputs off
// - timeout 10 min, hold extends to 100h
// - hold rising again with ext on restarts the running sequence's timeout at 10 min
// - bad signal sequence gives interlock, faulty error
// - switch 4s without field, protective mode
// - reset button in protective mode restarts gating
// - no restart within one hour, interlock
// - field, one beam free, switch: restart needed
// - valid press 0.15-4s restarts, outputs on
// - valid gating after press continues sequence
// - signal output toggles until outputs on
// - field, both beams blocked, switch: override needed
// - start on antivalent change within 0.5s, switch alone when mode not 1/6 and ext off
// - field filter 2s modes 1/6, 1s mode 5 set in filt_lim, not used by the sequence
module gsc_top #(
    parameter CLK_HZ = `GSC_CLK_HZ,
    parameter TMO_MS = `GSC_TMO_MS,
    parameter TMO_EXT_MS = `GSC_TMO_EXT_MS,
    parameter SYNC_MS = `GSC_SYNC_MS,
    parameter PMODE_MS = `GSC_PMODE_MS,
    parameter NOFIELD_MS = `GSC_NOFIELD_MS
) (
    // clock and reset
    input wire CLK_SYS,
    input wire RST_N,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // machine control and sensor inputs
    input wire GATE_SWITCH,
    input wire TIMER_HOLD,
    input wire FIELD_INTERRUPTED,
    input wire SYNC_BEAMS_FREE_N,
    input wire RESTART_BUTTON,
    // outputs
    output reg SAFETY_OUTPUTS,
    output reg GATING_ACTIVE,
    output reg GATING_SIGNAL_OUTPUT,
    output reg RESTART_NEEDED,
    output reg OVERRIDE_NEEDED
);
    // ****************************************************************
    // timing constants
    // ****************************************************************
    localparam [31:0] MS_CYC = CLK_HZ / 1000;
    localparam [31:0] END_MS = `GSC_END_MS;
    localparam [31:0] PAIR_MS = `GSC_PAIR_MS;
    localparam [31:0] PMIN_MS = `GSC_PRESS_MIN_MS;
    localparam [31:0] PMAX_MS = `GSC_PRESS_MAX_MS;
    localparam [31:0] FLONG_MS = `GSC_FILT_LONG_MS;
    localparam [31:0] FSHORT_MS = `GSC_FILT_SHORT_MS;
    localparam [31:0] BLINK_MS = `GSC_BLINK_MS;
    localparam [31:0] T_TMO = TMO_MS;
    localparam [31:0] T_EXT = TMO_EXT_MS;
    localparam [31:0] T_SYNC = SYNC_MS;
    localparam [31:0] T_PM = PMODE_MS;
    localparam [31:0] T_NOF = NOFIELD_MS;
    // ****************************************************************
    // states
    // ****************************************************************
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_ARM = 6'h02;
    localparam [5:0] S_GATE = 6'h04;
    localparam [5:0] S_PROT = 6'h08;
    localparam [5:0] S_LOCK = 6'h10;
    localparam [5:0] S_END = 6'h20;
    // ****************************************************************
    // input synchronisation
    // ****************************************************************
    wire [4:0] sync_w;
    gsc_sync #(.W(5)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .din({GATE_SWITCH, TIMER_HOLD, FIELD_INTERRUPTED,
              SYNC_BEAMS_FREE_N, RESTART_BUTTON}),
        .dout(sync_w)
    );
    wire gs = sync_w[4];
    wire th = sync_w[3];
    wire fi = sync_w[2];
    wire beams_blk = sync_w[1];
    wire btn = sync_w[0];
    // ****************************************************************
    // millisecond tick
    // ****************************************************************
    reg [31:0] pre_q;
    wire tick = (pre_q == MS_CYC - 32'h00000001);
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            pre_q <= 32'h00000000;
        else if (tick)
            pre_q <= 32'h00000000;
        else
            pre_q <= pre_q + 32'h00000001;
    end
    // ****************************************************************
    // registers
    // ****************************************************************
    reg [31:0] ctrl_q;
    reg [2:0] err_q;
    reg [5:0] st_q;
    wire [2:0] mode = ctrl_q[`GSC_CTRL_MODE_MSB:`GSC_CTRL_MODE_LSB];
    wire ext_en = ctrl_q[`GSC_CTRL_EXT_BIT];
    wire m16 = (mode == `GSC_MODE_1) || (mode == `GSC_MODE_6);
    wire wr = PSEL && PENABLE && PWRITE;
    wire rd = PSEL && !PENABLE && !PWRITE;
    wire map_ok = (PADDR == `GSC_CTRL_OFS) || (PADDR == `GSC_STAT_OFS) ||
                  (PADDR == `GSC_ERR_OFS);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !map_ok;
    wire err_clr = wr && (PADDR == `GSC_ERR_OFS);
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= `GSC_CTRL_RESET;
            PRDATA <= 32'h00000000;
        end else begin
            if (wr && PADDR == `GSC_CTRL_OFS)
                ctrl_q <= PWDATA & 32'h0000000F;
            if (rd) begin
                case (PADDR)
                `GSC_CTRL_OFS: PRDATA <= ctrl_q;
                `GSC_STAT_OFS: PRDATA <= {21'h000000, OVERRIDE_NEEDED,
                    RESTART_NEEDED, GATING_SIGNAL_OUTPUT, GATING_ACTIVE,
                    SAFETY_OUTPUTS, st_q};
                `GSC_ERR_OFS: PRDATA <= {29'h00000000, err_q};
                default: PRDATA <= 32'h00000000;
                endcase
            end
        end
    end
    // ****************************************************************
    // input edges and pairing
    // ****************************************************************
    reg gs_q, th_q, btn_q;
    wire gs_rise = gs && !gs_q;
    wire gs_fall = !gs && gs_q;
    wire th_fall = !th && th_q;
    wire th_rise = th && !th_q;
    reg [31:0] pair_q;
    reg pgs_q, pth_q;
    reg [31:0] t_q;
    reg [31:0] lim_q;
    reg [31:0] filt_q;
    reg [31:0] sync_q;
    reg [31:0] press_q;
    reg [31:0] blink_q;
    reg btn_ok_q;
    reg blink_on_q;
    wire [31:0] filt_lim = m16 ? FLONG_MS : FSHORT_MS;
    wire release_btn = !btn && btn_q;
    wire press_valid = release_btn && (press_q >= PMIN_MS) &&
                       (press_q <= PMAX_MS);
    // ****************************************************************
    // sequence control
    // ****************************************************************
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= S_IDLE;
            gs_q <= 1'b0;
            th_q <= 1'b0;
            btn_q <= 1'b0;
            pair_q <= 32'h00000000;
            pgs_q <= 1'b0;
            pth_q <= 1'b0;
            t_q <= 32'h00000000;
            lim_q <= 32'h00000000;
            filt_q <= 32'h00000000;
            sync_q <= 32'h00000000;
            press_q <= 32'h00000000;
            blink_q <= 32'h00000000;
            blink_on_q <= 1'b0;
            btn_ok_q <= 1'b0;
            err_q <= 3'h0;
            SAFETY_OUTPUTS <= 1'b0;
            GATING_ACTIVE <= 1'b0;
            GATING_SIGNAL_OUTPUT <= 1'b0;
            RESTART_NEEDED <= 1'b0;
            OVERRIDE_NEEDED <= 1'b0;
        end else begin
            gs_q <= gs;
            th_q <= th;
            btn_q <= btn;
            btn_ok_q <= press_valid;
            if (err_clr)
                err_q <= err_q & ~PWDATA[2:0];
            // button hold time in ms
            if (!btn)
                press_q <= 32'h00000000;
            else if (tick && press_q != 32'hFFFFFFFF)
                press_q <= press_q + 32'h00000001;
            // sync beam loss watch
            if (!beams_blk)
                sync_q <= 32'h00000000;
            else if (tick && sync_q <= T_SYNC)
                sync_q <= sync_q + 32'h00000001;
            // restart or override needed while gating signals present
            RESTART_NEEDED <= fi && !beams_blk && gs && (!m16 || th)
                && !GATING_ACTIVE;
            OVERRIDE_NEEDED <= fi && beams_blk && gs && (!m16 || th)
                && !GATING_ACTIVE;
            // signal output blinks while outputs stay off after fault
            if (tick) begin
                if (blink_q >= BLINK_MS - 32'h00000001) begin
                    blink_q <= 32'h00000000;
                    blink_on_q <= !blink_on_q;
                end else
                    blink_q <= blink_q + 32'h00000001;
            end
            if (tick)
                t_q <= t_q + 32'h00000001;
            case (st_q)
            S_IDLE: begin
                GATING_ACTIVE <= 1'b0;
                GATING_SIGNAL_OUTPUT <= 1'b1;
                SAFETY_OUTPUTS <= !fi && sync_q <= T_SYNC;
                if (gs_rise || th_fall) begin
                    pgs_q <= gs_rise;
                    pth_q <= th_fall;
                    pair_q <= 32'h00000000;
                    st_q <= S_ARM;
                end
            end
            S_ARM: begin
                // second edge must follow within the pairing window
                if (gs_rise)
                    pgs_q <= 1'b1;
                if (th_fall)
                    pth_q <= 1'b1;
                if (tick)
                    pair_q <= pair_q + 32'h00000001;
                if ((pgs_q || gs_rise) && (pth_q || th_fall || !ext_en &&
                    !m16)) begin
                    st_q <= S_GATE;
                    GATING_ACTIVE <= 1'b1;
                    t_q <= 32'h00000000;
                    filt_q <= 32'h00000000;
                    lim_q <= (ext_en && !th) ? T_EXT : T_TMO;
                end else if (pair_q >= PAIR_MS) begin
                    st_q <= S_LOCK;
                    err_q[`GSC_ERR_FAULTY_BIT] <= 1'b1;
                end
            end
            S_GATE: begin
                SAFETY_OUTPUTS <= 1'b1;
                GATING_SIGNAL_OUTPUT <= 1'b1;
                if (fi)
                    filt_q <= 32'h00000000;
                else if (tick)
                    filt_q <= filt_q + 32'h00000001;
                if (ext_en && th_rise) begin
                    t_q <= 32'h00000000;
                    lim_q <= T_TMO;
                end
                if (gs_fall) begin
                    st_q <= S_END;
                    t_q <= 32'h00000000;
                end else if (sync_q > T_SYNC) begin
                    st_q <= S_LOCK;
                    SAFETY_OUTPUTS <= 1'b0;
                    err_q[`GSC_ERR_SYNC_BIT] <= 1'b1;
                end else if (t_q >= lim_q) begin
                    st_q <= S_LOCK;
                    SAFETY_OUTPUTS <= 1'b0;
                    GATING_ACTIVE <= 1'b0;
                    err_q[`GSC_ERR_TIMEOUT_BIT] <= 1'b1;
                end else if (!fi && filt_q >= T_NOF && gs) begin
                    st_q <= S_PROT;
                    SAFETY_OUTPUTS <= 1'b0;
                    GATING_ACTIVE <= 1'b0;
                    t_q <= 32'h00000000;
                end else if (m16 && gs && th && th_q == th && !ext_en &&
                             !th_rise && t_q > PAIR_MS) begin
                    st_q <= S_LOCK;
                    err_q[`GSC_ERR_FAULTY_BIT] <= 1'b1;
                end
            end
            S_END: begin
                // end of gating well inside the 100 ms bound
                GATING_ACTIVE <= 1'b0;
                if (t_q >= END_MS - 32'h00000001 || !fi) begin
                    st_q <= S_IDLE;
                    SAFETY_OUTPUTS <= !fi && sync_q <= T_SYNC;
                end
            end
            S_PROT: begin
                SAFETY_OUTPUTS <= 1'b0;
                GATING_SIGNAL_OUTPUT <= blink_on_q;
                if (btn_ok_q && !fi) begin
                    st_q <= S_GATE;
                    GATING_ACTIVE <= 1'b1;
                    t_q <= 32'h00000000;
                    filt_q <= 32'h00000000;
                    lim_q <= T_TMO;
                end else if (t_q >= T_PM) begin
                    st_q <= S_LOCK;
                end
            end
            S_LOCK: begin
                SAFETY_OUTPUTS <= 1'b0;
                GATING_ACTIVE <= 1'b0;
                GATING_SIGNAL_OUTPUT <= blink_on_q;
                if (btn_ok_q && err_q == 3'h0) begin
                    if (gs && fi && (!m16 || th)) begin
                        st_q <= S_GATE;
                        GATING_ACTIVE <= 1'b1;
                        t_q <= 32'h00000000;
                        filt_q <= 32'h00000000;
                        lim_q <= T_TMO;
                    end else
                        st_q <= S_IDLE;
                    SAFETY_OUTPUTS <= 1'b1;
                end
            end
            default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule // gsc_top
`default_nettype wire

// file: verif/gsc_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// machine control and reset button
// ****************
module gsc_ctl_model #(
    parameter int CPM = 2
) (
    // clock
    input wire logic clk,
    // control lines
    output logic gate_switch,
    output logic timer_hold,
    output logic restart_button
);
    initial begin
        gate_switch = 1'b0;
        timer_hold = 1'b1;
        restart_button = 1'b0;
    end
    task automatic wms(input int n);
        repeat (n * CPM) @(posedge clk);
    endtask
    // switch rises, hold falls after skew
    task automatic start(input logic hold, input int skew);
        @(posedge clk) gate_switch <= 1'b1;
        wms(skew);
        if (hold) timer_hold <= 1'b0;
    endtask
    task automatic stop(input logic hold);
        @(posedge clk) gate_switch <= 1'b0;
        if (hold) timer_hold <= 1'b1;
    endtask
    task automatic hold_rise();
        @(posedge clk) timer_hold <= 1'b1;
    endtask
    task automatic press(input int ms);
        @(posedge clk) restart_button <= 1'b1;
        wms(ms);
        restart_button <= 1'b0;
    endtask
endmodule // gsc_ctl_model
`default_nettype wire

// file: verif/gsc_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// gating sequence checker
// ****************
module gsc_chk #(
    parameter CLK_HZ = 2000,
    parameter TMO_MS = 20,
    parameter TMO_EXT_MS = 50,
    parameter SYNC_MS = 10,
    parameter PMODE_MS = 30,
    parameter NOFIELD_MS = 8
) (
    // clock and apb
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [11:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // control and status
    input wire logic GATE_SWITCH,
    input wire logic TIMER_HOLD,
    input wire logic FIELD_INTERRUPTED,
    input wire logic SYNC_BEAMS_FREE_N,
    input wire logic SAFETY_OUTPUTS,
    input wire logic GATING_ACTIVE,
    input wire logic RESTART_NEEDED,
    input wire logic OVERRIDE_NEEDED
);
    localparam int CPM = CLK_HZ / 1000;
    localparam int END_CYC = 100 * CPM + 16;
    logic [31:0] ga_q, sy_q, nf_q;
    logic th_q;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ga_q <= '0;
            sy_q <= '0;
            nf_q <= '0;
            th_q <= 1'b1;
        end else begin
            th_q <= TIMER_HOLD;
            ga_q <= (GATING_ACTIVE && !(TIMER_HOLD && !th_q)) ? ga_q + 1 : '0;
            sy_q <= SYNC_BEAMS_FREE_N ? sy_q + 1 : '0;
            nf_q <= (GATING_ACTIVE && GATE_SWITCH && !FIELD_INTERRUPTED) ?
                nf_q + 1 : '0;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    a_apb_ready: assert property (PSEL |-> PREADY)
        else $error("pready low");
    a_bad_slverr: assert property (PSEL && PENABLE && PADDR > 12'h008
        |-> PSLVERR) else $error("no slave error");
    a_ok_noerr: assert property (PSEL && PENABLE && PADDR[1:0] == 2'h0
        && PADDR <= 12'h008 |-> !PSLVERR) else $error("false slave error");
    a_end_bound: assert property ($fell(GATE_SWITCH) && GATING_ACTIVE
        |-> ##[1:END_CYC] !GATING_ACTIVE) else $error("gating end late");
    a_tmo_bound: assert property (ga_q <= TMO_EXT_MS * CPM + 16)
        else $error("gating timeout missed");
    a_sync_off: assert property (sy_q > SYNC_MS * CPM + 16
        |-> !SAFETY_OUTPUTS) else $error("outputs on after sync loss");
    a_nofield_cap: assert property (nf_q <= NOFIELD_MS * CPM + 16)
        else $error("no protective mode");
    a_need_excl: assert property (!(RESTART_NEEDED && OVERRIDE_NEEDED))
        else $error("restart and override both needed");
endmodule // gsc_chk
bind gsc_top gsc_chk #(
    .CLK_HZ(CLK_HZ), .TMO_MS(TMO_MS), .TMO_EXT_MS(TMO_EXT_MS),
    .SYNC_MS(SYNC_MS), .PMODE_MS(PMODE_MS), .NOFIELD_MS(NOFIELD_MS)
) i_gsc_chk (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .GATE_SWITCH(GATE_SWITCH), .TIMER_HOLD(TIMER_HOLD),
    .FIELD_INTERRUPTED(FIELD_INTERRUPTED),
    .SYNC_BEAMS_FREE_N(SYNC_BEAMS_FREE_N), .SAFETY_OUTPUTS(SAFETY_OUTPUTS),
    .GATING_ACTIVE(GATING_ACTIVE), .RESTART_NEEDED(RESTART_NEEDED),
    .OVERRIDE_NEEDED(OVERRIDE_NEEDED)
);
`default_nettype wire

// file: verif/gsc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// gating sequence bench
// ****************
module gsc_top_tb;
    localparam int CPM = 2;
    localparam logic [5:0] S_IDLE = 6'h01;
    localparam logic [5:0] S_GATE = 6'h04;
    localparam logic [5:0] S_PROT = 6'h08;
    localparam logic [5:0] S_LOCK = 6'h10;
    logic clk, rst_n, psel, pen, pwr, fld, syn_n, er, prev;
    logic [11:0] pa;
    logic [31:0] pwd, rd, seed;
    wire logic gsw, th, btn, rdy, serr, safe, ga, sig, rneed, oneed;
    wire logic [31:0] prd;
    int n_mismatch, check_count, cyc, n;
    gsc_top #(.CLK_HZ(2000), .TMO_MS(20), .TMO_EXT_MS(50), .SYNC_MS(10),
        .PMODE_MS(2000), .NOFIELD_MS(8)) i_gsc_top (
        .CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(rdy), .PSLVERR(serr), .GATE_SWITCH(gsw), .TIMER_HOLD(th),
        .FIELD_INTERRUPTED(fld), .SYNC_BEAMS_FREE_N(syn_n),
        .RESTART_BUTTON(btn), .SAFETY_OUTPUTS(safe), .GATING_ACTIVE(ga),
        .GATING_SIGNAL_OUTPUT(sig), .RESTART_NEEDED(rneed),
        .OVERRIDE_NEEDED(oneed));
    gsc_ctl_model #(.CPM(CPM)) u_ctl (.clk(clk), .gate_switch(gsw),
        .timer_hold(th), .restart_button(btn));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic wms(input int ms);
        repeat (ms * CPM) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        er = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic chk_st(input logic [5:0] st);
        apb(1'b0, 12'h004, 32'h0);
        chk("state", {26'h0, st}, {26'h0, rd[5:0]});
        if (st != S_IDLE) begin
            chk("safety", {31'h0, st == S_GATE}, {31'h0, rd[6]});
            chk("safety_pin", {31'h0, st == S_GATE}, {31'h0, safe});
            chk("gating", {31'h0, st == S_GATE}, {31'h0, ga});
        end
    endtask
    task automatic recover(input logic [5:0] st);
        apb(1'b1, 12'h008, rnd() | 32'h7);
        apb(1'b0, 12'h008, 32'h0);
        chk("err_clear", 32'h0, rd & 32'h7);
        u_ctl.press(200 + rnd() % 800);
        wms(5);
        chk_st(st);
    endtask
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        {rst_n, psel, pen, pwr, fld, syn_n} = 6'h00;
        pa = 12'h000;
        pwd = 32'h0;
        seed = 32'hCD74;
        cyc = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_reset", 32'h00000005, rd);
        chk_st(S_IDLE);
        apb(1'b1, 12'h00C | 12'(rnd() & 32'h00000FF0), rnd());
        chk("unmapped_err", 32'h1, {31'h0, er});
        for (int m = 1; m < 7; m += 5) begin
            apb(1'b1, 12'h000, m);
            u_ctl.start(1'b1, rnd() % 4);
            wms(5);
            fld <= 1'b1;
            chk_st(S_GATE);
            fld <= 1'b0;
            u_ctl.stop(1'b1);
            wms(100);
            chk_st(S_IDLE);
        end
        u_ctl.start(1'b0, 0);
        wms(600);
        chk_st(S_LOCK);
        apb(1'b0, 12'h008, 32'h0);
        chk("err_faulty", 32'h2, rd & 32'h2);
        u_ctl.stop(1'b0);
        recover(S_IDLE);
        apb(1'b1, 12'h000, 32'h5);
        u_ctl.start(1'b0, 0);
        wms(4);
        chk_st(S_GATE);
        for (int i = 0; i < 3; i++) begin
            wms(12);
            chk_st(S_PROT);
            if (i == 2) break;
            u_ctl.press(200 + rnd() % 800);
            wms(5);
            chk_st(S_GATE);
        end
        n = 0;
        prev = sig;
        repeat (1100 * CPM) begin
            @(posedge clk);
            if (sig !== prev) n++;
            prev = sig;
            // random field and beam noise, no restart without button
            rd = rnd();
            fld <= rd[0];
            syn_n <= rd[1];
        end
        fld <= 1'b0;
        syn_n <= 1'b0;
        chk("blink", 32'h1, {31'h0, n >= 2});
        wms(1000);
        chk_st(S_LOCK);
        u_ctl.stop(1'b0);
        recover(S_IDLE);
        u_ctl.start(1'b0, 0);
        wms(2);
        fld <= 1'b1;
        wms(24);
        chk_st(S_LOCK);
        apb(1'b0, 12'h008, 32'h0);
        chk("err_timeout", 32'h1, rd & 32'h1);
        chk("restart_needed", 32'h1, {31'h0, rneed});
        recover(S_GATE);
        syn_n <= 1'b1;
        wms(14);
        chk_st(S_LOCK);
        chk("override_needed", 32'h1, {31'h0, oneed});
        apb(1'b0, 12'h008, 32'h0);
        chk("err_sync", 32'h4, rd & 32'h4);
        fld <= 1'b0;
        syn_n <= 1'b0;
        u_ctl.stop(1'b0);
        recover(S_IDLE);
        apb(1'b1, 12'h000, 32'hD);
        u_ctl.start(1'b1, rnd() % 4);
        wms(2);
        fld <= 1'b1;
        wms(40);
        chk_st(S_GATE);
        u_ctl.hold_rise();
        wms(15);
        chk_st(S_GATE);
        wms(10);
        chk_st(S_LOCK);
        fld <= 1'b0;
        u_ctl.stop(1'b0);
        recover(S_IDLE);
        summarize();
    end
endmodule // gsc_top_tb
`default_nettype wire
